// ---- apc_pkg.sv ----
// constants for the auxiliary pin function control block
package apc_pkg;
  // register index as printed; the apb byte address is four times it
  localparam logic [6:0]  REG_INDEX     = 7'h63;
  localparam logic [11:0] REG_ADDR      = {3'h0, REG_INDEX, 2'h0};
  localparam int          ADDR_W        = 12;

  // field positions
  localparam int          FUNC_HI       = 7;
  localparam int          FUNC_LO       = 4;
  localparam int          OUTVAL_POS    = 3;
  localparam int          INVAL_POS     = 2;
  localparam int          REPEAT_POS    = 1;

  // reset values
  localparam logic [3:0]  FUNC_RST      = 4'h0;
  localparam logic        OUTVAL_RST    = 1'h0;
  localparam logic        INVAL_RST     = 1'h0;
  localparam logic        REPEAT_RST    = 1'h0;

  // function codes
  localparam logic [3:0]  FN_DISABLED   = 4'h0;
  localparam logic [3:0]  FN_RESERVED   = 4'h1;
  localparam logic [3:0]  FN_JACK       = 4'h2;
  localparam logic [3:0]  FN_GPIN       = 4'h3;
  localparam logic [3:0]  FN_GPOUT      = 4'h4;
  localparam logic [3:0]  FN_MIC_LO     = 4'h5;
  localparam logic [3:0]  FN_MIC_HI     = 4'h7;
  localparam logic [3:0]  FN_BITCLK     = 4'h8;
  localparam logic [3:0]  FN_HS_BTN     = 4'h9;
  localparam logic [3:0]  FN_ALL4       = 4'hA;
  localparam logic [3:0]  FN_SC_NOISE   = 4'hB;
  localparam logic [3:0]  FN_SC_BTN     = 4'hC;
  localparam logic [3:0]  FN_SC         = 4'hD;
  localparam logic [3:0]  FN_NOISE      = 4'hE;
  localparam logic [3:0]  FN_BTN        = 4'hF;

  // timing
  localparam int          CLK_PERIOD_NS = 25;
  localparam int          INT_PULSE_NS  = 2000000;
  localparam int          JACK_PULSE_NS = 1750000;
  localparam int          INT_PULSE_CYC = INT_PULSE_NS / CLK_PERIOD_NS;
  localparam int          JACK_PULSE_CYC = JACK_PULSE_NS / CLK_PERIOD_NS;
  localparam int          CNT_W         = 17;
endpackage : apc_pkg

// ---- apc_aux_pin.sv ----
// function selection and control for one multipurpose audio codec pin
//
// Function
// [R1] bits 7:4 pick pin function, reset zero; zero leaves pin fully idle
// [R2] software never writes code 0001, it is reserved
// [R3] code 0010 outputs jack detect interrupt, active high, about 1.75 ms
// [R4] code 0011 makes the pin an input, level shown in input bit
// [R5] code 0100 makes the pin an output driving the output value bit
// [R6] codes 0101-0111 take mic data on both mic clock edges
// [R7] code 1000 carries serial bit clock, direction set elsewhere
// [R8] code 1001 outputs headset OR button interrupt
// [R9] code 1010 outputs headset OR button OR short OR noise
// [R10] code 1011 outputs short-circuit OR noise interrupt
// [R11] code 1100 outputs short-circuit OR button interrupt
// [R12] code 1101 outputs only the short-circuit interrupt
// [R13] code 1110 outputs only the noise interrupt
// [R14] code 1111 outputs the button or hookswitch interrupt
// [R15] bit 3 is output level, reset zero, used as output
// [R16] bit 2 read-only, shows the level on the pin, reset zero
// [R17] bit 1 zero: each interrupt is one high pulse of about 2 ms; the code 0010 jack pulse is about 1.75 ms here
// [R18] bit 1 one: pulses repeat until the flags register is read
// [R19] software never writes bit 0; it reads zero
// [R20] driver released whenever the function is not an output
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module apc_aux_pin #(
  parameter int PULSE_CYC = apc_pkg::INT_PULSE_CYC,
  parameter int JACK_CYC  = apc_pkg::JACK_PULSE_CYC
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rstn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [apc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  input  wire logic                      pinIn,
  output var  logic                      pinOut,
  output var  logic                      pinOeN,
  input  wire logic                      headsetIrq,
  input  wire logic                      buttonIrq,
  input  wire logic                      shortIrq,
  input  wire logic                      noiseIrq,
  input  wire logic                      flagsRead,
  input  wire logic                      micClk,
  output var  logic                      micRiseData,
  output var  logic                      micFallData,
  input  wire logic                      bitClkDirOut,
  input  wire logic                      bitClkSrc,
  output var  logic                      bitClkFromPin
);

  typedef enum logic [2:0] {
    PS_IDLE = 3'h1,
    PS_HIGH = 3'h2,
    PS_GAP  = 3'h4
  } apc_pulse_t;

  typedef struct packed {
    logic [3:0]               func;
    logic                     outVal;
    logic                     inVal;
    logic                     repeatMode;
    apc_pulse_t               pState;
    logic [apc_pkg::CNT_W-1:0] cnt;
    logic                     srcPrev;
    logic                     readSeen;
    logic                     micPrev;
    logic                     micRise;
    logic                     micFall;
    logic                     pinOut;
    logic                     pinOeN;
    logic                     bitClkIn;
    logic [31:0]              prdata;
    logic                     pready;
    logic                     pslverr;
  } apc_state_t;

  localparam logic [apc_pkg::CNT_W-1:0] PULSE_LAST = apc_pkg::CNT_W'(PULSE_CYC - 1);
  localparam logic [apc_pkg::CNT_W-1:0] JACK_LAST  = apc_pkg::CNT_W'(JACK_CYC - 1);

  apc_state_t st_q;
  apc_state_t st_d;

  logic intSrc;
  logic intFunc;
  logic isMic;
  logic hit;
  logic wrAcc;

  // interrupt source selection by function code
  always_comb
  begin
    intFunc = 1'b1;
    case (st_q.func)
      // [R3] jack detect alone
      apc_pkg::FN_JACK:     intSrc = headsetIrq;
      // [R8] headset or button
      apc_pkg::FN_HS_BTN:   intSrc = headsetIrq | buttonIrq;
      // [R9] four sources
      apc_pkg::FN_ALL4:     intSrc = headsetIrq | buttonIrq | shortIrq | noiseIrq;
      // [R10] short or noise
      apc_pkg::FN_SC_NOISE: intSrc = shortIrq | noiseIrq;
      // [R11] short or button
      apc_pkg::FN_SC_BTN:   intSrc = shortIrq | buttonIrq;
      // [R12] short only
      apc_pkg::FN_SC:       intSrc = shortIrq;
      // [R13] noise only
      apc_pkg::FN_NOISE:    intSrc = noiseIrq;
      // [R14] button or hookswitch
      apc_pkg::FN_BTN:      intSrc = buttonIrq;
      default:
      begin
        intSrc  = 1'b0;
        intFunc = 1'b0;
      end
    endcase
  end

  assign isMic = (st_q.func >= apc_pkg::FN_MIC_LO) && (st_q.func <= apc_pkg::FN_MIC_HI);
  assign hit   = (paddr == apc_pkg::REG_ADDR);
  assign wrAcc = psel && penable && st_q.pready && pwrite && hit;

  always_comb
  begin
    st_d = st_q;

    // apc bus: pready rises in the access cycle, zero wait states
    st_d.pready  = psel && !penable;
    st_d.pslverr = psel && !penable && !hit;
    st_d.prdata  = 32'h0000_0000;
    if (psel && !penable && hit && !pwrite)
    begin
      // [R19] bit 0 reads zero
      st_d.prdata[apc_pkg::FUNC_HI:apc_pkg::FUNC_LO] = st_q.func;
      st_d.prdata[apc_pkg::OUTVAL_POS]               = st_q.outVal;
      st_d.prdata[apc_pkg::INVAL_POS]                = st_q.inVal;
      st_d.prdata[apc_pkg::REPEAT_POS]               = st_q.repeatMode;
    end
    if (wrAcc)
    begin
      // [R1] function field write
      st_d.func       = pwdata[apc_pkg::FUNC_HI:apc_pkg::FUNC_LO];
      // [R15] output level bit
      st_d.outVal     = pwdata[apc_pkg::OUTVAL_POS];
      st_d.repeatMode = pwdata[apc_pkg::REPEAT_POS];
    end

    // [R4] input level sampled for status
    // [R16] pin level tracked in every mode
    st_d.inVal = pinIn;

    // [R6] both mic clock edges capture data; micClk is sampled, so it
    // must stay well below half the system clock
    st_d.micPrev = micClk;
    if (isMic && micClk && !st_q.micPrev)
      st_d.micRise = pinIn;
    if (isMic && !micClk && st_q.micPrev)
      st_d.micFall = pinIn;

    // [R7] bit clock seen from the pin when it is an input
    st_d.bitClkIn = (st_q.func == apc_pkg::FN_BITCLK) ? pinIn : 1'b0;

    // interrupt pulse machine, triggered on a rising source
    st_d.srcPrev = intSrc;
    case (st_q.pState)
      PS_IDLE:
      begin
        if (intFunc && intSrc && !st_q.srcPrev)
        begin
          st_d.pState = PS_HIGH;
          st_d.readSeen = 1'b0;
          // [R3] jack selection uses the shorter pulse
          st_d.cnt = (st_q.func == apc_pkg::FN_JACK) ? JACK_LAST : PULSE_LAST;
        end
      end
      PS_HIGH:
      begin
        // [R18] a read here must not be lost before the pulse ends
        if (flagsRead)
          st_d.readSeen = 1'b1;
        if (!intFunc)
          st_d.pState = PS_IDLE;
        else if (st_q.cnt != '0)
          st_d.cnt = st_q.cnt - 1'b1;
        // [R18] repeating mode leaves a gap and fires again
        else if (st_q.repeatMode && !flagsRead && !st_q.readSeen)
        begin
          st_d.pState = PS_GAP;
          st_d.cnt    = PULSE_LAST;
        end
        // [R17] single pulse ends here
        else
          st_d.pState = PS_IDLE;
      end
      PS_GAP:
      begin
        // [R18] a read of the flags ends the train
        if (!intFunc || flagsRead || !st_q.repeatMode)
          st_d.pState = PS_IDLE;
        else if (st_q.cnt != '0)
          st_d.cnt = st_q.cnt - 1'b1;
        else
        begin
          st_d.pState = PS_HIGH;
          st_d.cnt = (st_q.func == apc_pkg::FN_JACK) ? JACK_LAST : PULSE_LAST;
        end
      end
      default:
        st_d.pState = PS_IDLE;
    endcase

    // pin driver; flagsRead in the high phase does not cut the pulse short
    // [R20] released unless the function drives
    st_d.pinOeN = 1'b1;
    st_d.pinOut = 1'b0;
    if (st_q.func == apc_pkg::FN_GPOUT)
    begin
      // [R5] drive the output level bit
      st_d.pinOeN = 1'b0;
      st_d.pinOut = st_q.outVal;
    end
    else if (st_q.func == apc_pkg::FN_BITCLK && bitClkDirOut)
    begin
      // [R7] bit clock driven out
      st_d.pinOeN = 1'b0;
      st_d.pinOut = bitClkSrc;
    end
    else if (intFunc)
    begin
      st_d.pinOeN = 1'b0;
      st_d.pinOut = (st_q.pState == PS_HIGH);
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q            <= '0;
      st_q.func       <= apc_pkg::FUNC_RST;
      st_q.outVal     <= apc_pkg::OUTVAL_RST;
      st_q.inVal      <= apc_pkg::INVAL_RST;
      st_q.repeatMode <= apc_pkg::REPEAT_RST;
      st_q.pState     <= PS_IDLE;
      st_q.pinOeN     <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign prdata        = st_q.prdata;
  assign pready        = st_q.pready;
  assign pslverr       = st_q.pslverr;
  assign pinOut        = st_q.pinOut;
  assign pinOeN        = st_q.pinOeN;
  assign micRiseData   = st_q.micRise;
  assign micFallData   = st_q.micFall;
  assign bitClkFromPin = st_q.bitClkIn;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_setup;
    psel && !penable && hit;
  endsequence

  sequence s_access;
    psel && penable && pready;
  endsequence

  // [R1] disabled pin stays released
  a_disabled_release: assert property (st_q.func == apc_pkg::FN_DISABLED |=> pinOeN) // [R1]
    else $error("pin driven while disabled");

  // [R5] output drives the stored level
  a_gpout_drive: assert property (st_q.func == apc_pkg::FN_GPOUT |=> // [R5]
      !pinOeN && pinOut == $past(st_q.outVal))
    else $error("general output level wrong");

  // [R16] input bit follows the pin
  a_input_value: assert property (##1 st_q.inVal == $past(pinIn)) // [R16]
    else $error("input bit does not follow pin");

  // [R6] rising mic edge captures the pin
  a_mic_capture: assert property (isMic && micClk && !st_q.micPrev |=> // [R6]
      micRiseData == $past(pinIn))
    else $error("mic rising capture missed");

  // [R20] input bit clock leaves pin released
  a_bitclk_release: assert property (st_q.func == apc_pkg::FN_BITCLK && !bitClkDirOut |=> // [R20]
      pinOeN)
    else $error("bit clock input drives pin");

  // [R17] single pulse mode returns to idle
  a_pulse_single: assert property (st_q.pState == PS_HIGH && st_q.cnt == '0 && intFunc && // [R17]
      !st_q.repeatMode |=> st_q.pState == PS_IDLE ##1 !pinOut)
    else $error("single pulse did not end");

  // [R3] jack pulse loads its own length
  a_jack_length: assert property (st_q.pState == PS_IDLE && // [R3]
      st_q.func == apc_pkg::FN_JACK && headsetIrq && !st_q.srcPrev |=>
      st_q.pState == PS_HIGH && st_q.cnt == JACK_LAST ##1 pinOut)
    else $error("jack pulse start wrong");

  // [R18] a flags read stops the repeat train
  a_repeat_stop: assert property (st_q.pState == PS_GAP && flagsRead |=> // [R18]
      st_q.pState == PS_IDLE)
    else $error("repeat train not stopped");

  // [R19] reserved bit reads zero
  a_reserved_zero: assert property (s_setup ##1 s_access |-> prdata[0] == 1'b0) // [R19]
    else $error("reserved bit read nonzero");

  // [R1] a write updates the function field
  a_write_func: assert property (s_setup ##1 (s_access and pwrite) |=> // [R1]
      st_q.func == $past(pwdata[apc_pkg::FUNC_HI:apc_pkg::FUNC_LO]))
    else $error("function field not written");

  sequence s_read_high;
    st_q.pState == PS_HIGH && intFunc && flagsRead;
  endsequence

  // [R18] a flags read in the high phase is kept
  a_read_in_high: assert property (s_read_high |=> st_q.readSeen) // [R18]
    else $error("flags read in high phase lost");

  // [R18] pulse end after a kept read stops the train
  a_train_end: assert property (st_q.pState == PS_HIGH && st_q.cnt == '0 && // [R18]
      st_q.readSeen && intFunc |=> st_q.pState == PS_IDLE)
    else $error("train went on after flags read");

  // [R4] input selection reports the pin level
  a_gpin_status: assert property (st_q.func == apc_pkg::FN_GPIN |=> // [R4]
      st_q.inVal == $past(pinIn))
    else $error("input status bit wrong");

  // [R17] a pulse in progress drives the pin high
  a_pulse_drive: assert property (st_q.pState == PS_HIGH && intFunc |=> // [R17]
      !pinOeN && pinOut)
    else $error("pulse not driven on pin");

endmodule : apc_aux_pin

`default_nettype wire

// ---- apc_pin_model.sv ----
// far-side circuit model wired to the multipurpose pin
`timescale 1ns/1ps
`default_nettype none

module apc_pin_model (
  input  wire logic sys_clk,
  input  wire logic pinOut,
  input  wire logic pinOeN,
  input  wire logic extEn,
  input  wire logic extLvl,
  output var  logic pinIn
);
  logic lastQ;

  always_ff @(posedge sys_clk)
    lastQ <= pinIn;

  // no pull on this net: an undriven pin flips every cycle
  always_comb
  begin
    if (!pinOeN)
      pinIn = pinOut;
    else if (extEn)
      pinIn = extLvl;
    else
      pinIn = ~lastQ;
  end
endmodule // apc_pin_model

`default_nettype wire

// ---- tb_aux_pin_function_control.sv ----
// self-checking bench for the auxiliary pin function block
`timescale 1ns/1ps
`default_nettype none

module tb_aux_pin_function_control;
  localparam int          PC = 8;
  localparam int          JC = 6;
  localparam logic [11:0] RA = apc_pkg::REG_ADDR;
  logic        sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic        pready, pslverr, err, pinIn, pinOut, pinOeN;
  logic        micRiseData, micFallData, bitClkFromPin;
  logic [3:0]  irq = '0;
  logic        flagsRead = 0, micClk = 0, bitClkDirOut = 0, bitClkSrc = 0;
  logic        extEn = 1, extLvl = 0;
  int          fails = 0, compares = 0, regM = 0, v, hi, rises;
  int          codes[6] = '{0, 3, 5, 6, 7, 8};

  always #12.5 sys_clk = ~sys_clk;

  apc_aux_pin #(.PULSE_CYC(PC), .JACK_CYC(JC)) uut (.sys_clk(sys_clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .pinIn(pinIn),
    .pinOut(pinOut), .pinOeN(pinOeN), .headsetIrq(irq[0]), .buttonIrq(irq[1]),
    .shortIrq(irq[2]), .noiseIrq(irq[3]), .flagsRead(flagsRead), .micClk(micClk),
    .micRiseData(micRiseData), .micFallData(micFallData), .bitClkDirOut(bitClkDirOut),
    .bitClkSrc(bitClkSrc), .bitClkFromPin(bitClkFromPin));

  apc_pin_model far (.sys_clk(sys_clk), .pinOut(pinOut), .pinOeN(pinOeN),
    .extEn(extEn), .extLvl(extLvl), .pinIn(pinIn));

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      fails++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge sys_clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1 && ++t < 50);
    if (t >= 50)
      fails++;
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (w && a == RA)
      regM = d & 32'hFA;
  endtask

  task rdChk(input string nm, input logic pl);
    apb(0, RA, 32'h0);
    chk(nm, 32'(regM) | {29'h0, pl, 2'h0}, rd);
    chk("read error", 0, err);
  endtask

  task wrSet(input int c, input int o);
    apb(1, RA, {24'h0, c[3:0], o[0], 3'h0});
    repeat (3) @(posedge sys_clk);
  endtask

  task irqRun(input int s, input int win);
    logic prev;
    prev = 0;
    hi = 0;
    rises = 0;
    @(posedge sys_clk);
    irq[s] <= 1;
    @(posedge sys_clk);
    irq[s] <= 0;
    repeat (win)
    begin
      @(negedge sys_clk);
      hi += int'(pinOut === 1'b1);
      rises += int'(pinOut === 1'b1 && !prev);
      prev = pinOut;
    end
  endtask

  task quiet(input string nm);
    hi = 0;
    repeat (40)
    begin
      @(posedge sys_clk);
      hi += int'(pinOut === 1'b1);
    end
    chk(nm, 0, hi);
  endtask

  // source mask bits: headset, button, short, noise
  function int expW(input int c, input int s);
    int m;
    case (c)
      2: m = 1;
      9: m = 3;
      10: m = 15;
      11: m = 12;
      12: m = 6;
      13: m = 4;
      14: m = 8;
      default: m = 2;
    endcase
    return m[s] ? (c == 2 ? JC : PC) : 0;
  endfunction

  task results();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial
  begin
    #(25 * 30000);
    fails++;
    results();
  end

  initial
  begin
    void'($urandom(26));
    repeat (2) @(posedge sys_clk);
    rstn <= 1;
    rdChk("reset value", 0);
    apb(1, 12'h004, 32'hF0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
    rdChk("after unmapped write", 0);
    extEn <= 0;
    repeat (4)
    begin
      v = $urandom % 2;
      wrSet(4, v);
      chk("gpout enable", 0, pinOeN);
      chk("gpout level", v, pinOut);
      rdChk("gpout readback", v[0]);
    end
    // reserved code never written; driver released
    extEn <= 1;
    foreach (codes[i])
    begin
      v = $urandom % 2;
      extLvl <= v[0];
      wrSet(codes[i], 0);
      chk("released", 1, pinOeN);
      rdChk("input level", v[0]);
      if (codes[i] == 8)
        chk("bitclk in", v, bitClkFromPin);
    end
    bitClkDirOut <= 1;
    extEn <= 0;
    repeat (4)
    begin
      v = $urandom % 2;
      bitClkSrc <= v[0];
      repeat (3) @(posedge sys_clk);
      chk("bitclk out", {1'b0, v[0]}, {pinOeN, pinOut});
    end
    bitClkDirOut <= 0;
    extEn <= 1;
    // data on both mic clock edges
    wrSet(5, 0);
    repeat (3)
    begin
      v = $urandom % 4;
      extLvl <= v[0];
      repeat (3) @(posedge sys_clk);
      micClk <= 1;
      repeat (4) @(posedge sys_clk);
      chk("mic rise", v[0], micRiseData);
      extLvl <= v[1];
      repeat (3) @(posedge sys_clk);
      micClk <= 0;
      repeat (4) @(posedge sys_clk);
      chk("mic fall", v[1], micFallData);
    end
    // every interrupt code against every source
    extEn <= 0;
    for (int c = 2; c < 16; c++)
    begin
      if (c > 2 && c < 9)
        continue;
      wrSet(c, 0);
      for (int s = 0; s < 4; s++)
      begin
        irqRun(s, 30);
        chk("pulse width", expW(c, s), hi);
      end
    end
    // repeat train ends after flags read
    apb(1, RA, 32'h92);
    repeat (3) @(posedge sys_clk);
    irqRun(0, 60);
    chk("repeat train", 1, rises >= 3);
    @(posedge sys_clk);
    flagsRead <= 1;
    @(posedge sys_clk);
    flagsRead <= 0;
    repeat (30) @(posedge sys_clk);
    quiet("train stopped");
    // a read in the high phase lets that pulse end, then stops the train
    irqRun(1, 4);
    @(posedge sys_clk);
    flagsRead <= 1;
    @(posedge sys_clk);
    flagsRead <= 0;
    repeat (10) @(posedge sys_clk);
    quiet("train stopped in high");
    results();
  end
endmodule // tb_aux_pin_function_control

`default_nettype wire
